// >>> logic/sas_pkg.sv
package sas_pkg;
  // Sizes
  localparam int NCH_DEF = 16;
  localparam int RES_W   = 12;
  localparam int ADDR_W  = 8;
  localparam int CNT_W   = 8;
  localparam int INT_W   = 2;

  // Register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_CHEN    = 8'h04;
  localparam logic [7:0] A_DIFF    = 8'h08;
  localparam logic [7:0] A_ACQ     = 8'h0C;
  localparam logic [7:0] A_LIM_LO  = 8'h10;
  localparam logic [7:0] A_LIM_HI  = 8'h14;
  localparam logic [7:0] A_INT_ST  = 8'h18;
  localparam logic [7:0] A_INT_CLR = 8'h1C;
  localparam logic [7:0] A_INT_EN  = 8'h20;
  localparam logic [7:0] A_BELOW   = 8'h24;
  localparam logic [7:0] A_ABOVE   = 8'h28;
  localparam logic [7:0] A_STATUS  = 8'h2C;
  localparam logic [7:0] A_RESULT  = 8'h40;

  // Control and status fields
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_START  = 1;
  localparam int CTRL_REF_LO = 2;
  localparam int CTRL_REFPIN = 4;
  localparam int CTRL_TBIAS  = 5;
  localparam int STAT_CH_LO  = 1;

  // Interrupt bits
  localparam int INT_DONE  = 0;
  localparam int INT_RANGE = 1;

  // Reference choices
  localparam logic [1:0] REF_VDDA = 2'h0;
  localparam logic [1:0] REF_HALF = 2'h1;
  localparam logic [1:0] REF_BG   = 2'h2;
  localparam logic [1:0] REF_EXT  = 2'h3;

  // Reset values
  localparam logic [7:0]  ACQ_RST    = 8'h04;
  localparam logic [11:0] LIM_LO_RST = 12'h000;
  localparam logic [11:0] LIM_HI_RST = 12'hFFF;

  // Conversion timing
  localparam int CONV_CLKS       = 18;
  localparam int CONV_CLK_MAX_HZ = 36_000_000;
  localparam int PCLK_PERIOD_NS  = 25;
  localparam int CONV_TIME_NS    = (CONV_CLKS * 1000 + CONV_CLK_MAX_HZ / 1_000_000 - 1)
                                   / (CONV_CLK_MAX_HZ / 1_000_000);
  localparam int CONV_CYC        = (CONV_TIME_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONV} sas_state_e;
endpackage

// >>> logic/sas_sticky.sv
`timescale 1ns/10ps
module sas_sticky #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Set and clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flags
  output logic      [W-1:0] q
);
  // Set wins over clear
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        q[i] <= 1'b0;
      else if (set[i])
        q[i] <= 1'b1;
      else if (clr[i])
        q[i] <= 1'b0;
    end
  end
endmodule

// >>> logic/sas_window.sv
`timescale 1ns/10ps
module sas_window #(
  parameter int W = 12
) (
  // Value and limits
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] lim_lo,
  input  wire logic [W-1:0] lim_hi,
  // Crossing
  output logic              below,
  output logic              above
);
  assign below = value < lim_lo;
  assign above = value > lim_hi;
endmodule

// >>> logic/sas_seq.sv
// Contract
// - Each conversion gets at least 18 clocks of a 36 MHz converter clock.
// - Reference is full supply, half supply, bandgap, or external on pin.
// - Every channel separately single-ended or differential within one scan.
// - Acquisition time is a programmable count of clocks.
// - Sequencer walks all enabled channels without software help.
// - No idle cycles between one channel and the next.
// - Per-channel result buffer; scan-done only after every enabled channel.
// - Each result checked against limits; range interrupt at once.
// - Converter halts in deep-sleep and hibernate states.
// - Temperature diode is a channel; its bias source can be switched off.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module sas_seq #(
  parameter int NCH = sas_pkg::NCH_DEF
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic [7:0]               paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Converter core
  output logic      [$clog2(NCH)-1:0]   mux_sel,
  output logic                          mux_diff,
  output logic                          temp_sel,
  output logic                          temp_bias_en,
  output logic      [1:0]               ref_sel,
  output logic                          ref_ext_pin,
  output logic                          sample_en,
  output logic                          conv_en,
  input  wire logic [sas_pkg::RES_W-1:0] adc_data,
  // System power state
  input  wire logic                     low_power,
  // Interrupt
  output logic                          irq
);
  localparam int CH_W = $clog2(NCH);
  localparam int RW   = sas_pkg::RES_W;
  localparam int TEMP_CH = NCH - 1;
  if (NCH < 2 || NCH > 16 || sas_pkg::CONV_CYC < 8 || sas_pkg::CONV_CYC >= 256)
  begin : g_bad_cfg
    $error("sas_seq: unsupported channel count or timing");
  end
  // Register map decode
  function automatic logic addr_ok(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a[1:0] == 2'h0)
    begin
      if (a < sas_pkg::A_RESULT)
        hit = a <= sas_pkg::A_STATUS;
      else
        hit = (a - sas_pkg::A_RESULT) < 8'(NCH * 4);
    end
    return hit;
  endfunction
  // Lowest enabled channel at or above start
  function automatic logic [CH_W:0] first_at(input logic [NCH-1:0] en,
                                             input logic [CH_W:0]  start);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (en[i] && i >= int'(start))
        r = {1'b1, CH_W'(i)};
    end
    return r;
  endfunction
  sas_pkg::sas_state_e state;
  logic [31:0]         ctrl;
  logic [NCH-1:0]      chen;
  logic [NCH-1:0]      diff;
  logic [7:0]          acq;
  logic [RW-1:0]       lim_lo;
  logic [RW-1:0]       lim_hi;
  logic [1:0]          int_en;
  logic [1:0]          int_st;
  logic [NCH-1:0]      below_q;
  logic [NCH-1:0]      above_q;
  logic [RW-1:0]       result [NCH];
  logic [CH_W-1:0]     ch;
  logic [7:0]          cnt;
  logic                start_pend;
  logic                hit_q;
  logic                wr;
  logic                rd_setup;
  logic                res_wr;
  logic                below;
  logic                above;
  logic                scan_done;
  logic [CH_W:0]       nxt;
  logic [CH_W:0]       first;
  logic [7:0]          acq_eff;
  logic [NCH-1:0]      ch_hot;

  // APB handshake: one setup, one access cycle
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit_q;
  assign wr       = psel & penable & pwrite & addr_ok(paddr);
  assign rd_setup = psel & ~penable;

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl   <= '0;
      chen   <= '0;
      diff   <= '0;
      acq    <= sas_pkg::ACQ_RST;
      lim_lo <= sas_pkg::LIM_LO_RST;
      lim_hi <= sas_pkg::LIM_HI_RST;
      int_en <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        sas_pkg::A_CTRL:   ctrl   <= pwdata;
        sas_pkg::A_CHEN:   chen   <= pwdata[NCH-1:0];
        sas_pkg::A_DIFF:   diff   <= pwdata[NCH-1:0];
        sas_pkg::A_ACQ:    acq    <= pwdata[7:0];
        sas_pkg::A_LIM_LO: lim_lo <= pwdata[RW-1:0];
        sas_pkg::A_LIM_HI: lim_hi <= pwdata[RW-1:0];
        sas_pkg::A_INT_EN: int_en <= pwdata[sas_pkg::INT_W-1:0];
        default:           ;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      hit_q  <= 1'b0;
    end
    else if (rd_setup)
    begin
      hit_q  <= addr_ok(paddr);
      prdata <= '0;
      if (!pwrite && addr_ok(paddr))
      begin
        case (paddr)
          sas_pkg::A_CTRL:   prdata <= ctrl & ~(32'h1 << sas_pkg::CTRL_START);
          sas_pkg::A_CHEN:   prdata <= 32'(chen);
          sas_pkg::A_DIFF:   prdata <= 32'(diff);
          sas_pkg::A_ACQ:    prdata <= 32'(acq);
          sas_pkg::A_LIM_LO: prdata <= 32'(lim_lo);
          sas_pkg::A_LIM_HI: prdata <= 32'(lim_hi);
          sas_pkg::A_INT_ST: prdata <= 32'(int_st);
          sas_pkg::A_INT_EN: prdata <= 32'(int_en);
          sas_pkg::A_BELOW:  prdata <= 32'(below_q);
          sas_pkg::A_ABOVE:  prdata <= 32'(above_q);
          sas_pkg::A_STATUS: prdata <= {25'h0, 6'(ch), (state != sas_pkg::S_IDLE)};
          default:
          begin
            if (paddr >= sas_pkg::A_RESULT)
              prdata <= 32'(result[CH_W'((paddr - sas_pkg::A_RESULT) >> 2)]);
          end
        endcase
      end
    end
  end

  // Analog configuration outputs
  assign ref_sel      = ctrl[sas_pkg::CTRL_REF_LO +: 2];
  assign ref_ext_pin  = ctrl[sas_pkg::CTRL_REFPIN];
  assign temp_bias_en = ctrl[sas_pkg::CTRL_TBIAS];
  assign mux_sel      = ch;
  assign mux_diff     = diff[ch];
  assign temp_sel     = (ch == CH_W'(TEMP_CH));
  assign sample_en    = (state == sas_pkg::S_SAMPLE);
  assign conv_en      = (state == sas_pkg::S_CONV);
  assign acq_eff = (acq == 8'h00) ? 8'h01 : acq;
  assign first   = first_at(chen, '0);
  assign nxt     = first_at(chen, (CH_W + 1)'(ch) + 1'b1);
  assign res_wr  = conv_en && cnt == 8'h00;
  assign scan_done = res_wr && !nxt[CH_W];
  // Single-scan request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_pend <= 1'b0;
    else if (wr && paddr == sas_pkg::A_CTRL && pwdata[sas_pkg::CTRL_START])
      start_pend <= 1'b1;
    else if (state == sas_pkg::S_IDLE && !low_power && first[CH_W])
      start_pend <= 1'b0;
  end

  // Scan sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= sas_pkg::S_IDLE;
      ch    <= '0;
      cnt   <= '0;
    end
    else if (low_power)
      state <= sas_pkg::S_IDLE;
    else
    begin
      case (state)
        sas_pkg::S_IDLE:
        begin
          if ((ctrl[sas_pkg::CTRL_RUN] || start_pend) && first[CH_W])
          begin
            ch    <= first[CH_W-1:0];
            cnt   <= acq_eff - 8'h01;
            state <= sas_pkg::S_SAMPLE;
          end
        end
        sas_pkg::S_SAMPLE:
        begin
          if (cnt == 8'h00)
          begin
            cnt   <= 8'(sas_pkg::CONV_CYC - 1);
            state <= sas_pkg::S_CONV;
          end
          else
            cnt <= cnt - 8'h01;
        end
        sas_pkg::S_CONV:
        begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else if (nxt[CH_W])
          begin
            ch    <= nxt[CH_W-1:0];
            cnt   <= acq_eff - 8'h01;
            state <= sas_pkg::S_SAMPLE;
          end
          else if (ctrl[sas_pkg::CTRL_RUN] && first[CH_W])
          begin
            ch    <= first[CH_W-1:0];
            cnt   <= acq_eff - 8'h01;
            state <= sas_pkg::S_SAMPLE;
          end
          else
            state <= sas_pkg::S_IDLE;
        end
        default: state <= sas_pkg::S_IDLE;
      endcase
    end
  end

  // Per-channel result buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NCH; i++)
        result[i] <= '0;
    end
    else if (res_wr)
      result[ch] <= adc_data;
  end

  sas_window #(
    .W (RW)
  ) u_window (
    .value  (adc_data),
    .lim_lo (lim_lo),
    .lim_hi (lim_hi),
    .below  (below),
    .above  (above)
  );
  assign ch_hot = NCH'(1) << ch;
  // Which limit, which channel
  sas_sticky #(
    .W (NCH)
  ) u_below (
    .pclk    (pclk),
    .presetn (presetn),
    .set     ((res_wr && below) ? ch_hot : '0),
    .clr     ((wr && paddr == sas_pkg::A_BELOW) ? pwdata[NCH-1:0] : '0),
    .q       (below_q)
  );
  sas_sticky #(
    .W (NCH)
  ) u_above (
    .pclk    (pclk),
    .presetn (presetn),
    .set     ((res_wr && above) ? ch_hot : '0),
    .clr     ((wr && paddr == sas_pkg::A_ABOVE) ? pwdata[NCH-1:0] : '0),
    .q       (above_q)
  );
  // Interrupt status
  sas_sticky #(
    .W (sas_pkg::INT_W)
  ) u_int (
    .pclk    (pclk),
    .presetn (presetn),
    .set     ({res_wr && (below || above), scan_done}),
    .clr     ((wr && paddr == sas_pkg::A_INT_CLR) ? pwdata[sas_pkg::INT_W-1:0] : '0),
    .q       (int_st)
  );
  assign irq = |(int_st & int_en);
  // Checks
  localparam int A_CONV_TAIL = sas_pkg::CONV_CYC - 7;
  logic [7:0] a_len;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      a_len <= '0;
    else if (sample_en)
      a_len <= a_len + 8'h01;
    else
      a_len <= '0;
  end
  property p_conv_len;
    @(posedge pclk) disable iff (!presetn || low_power)
    $rose(conv_en) |-> conv_en[*8] ##A_CONV_TAIL !conv_en;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_ref;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == sas_pkg::A_CTRL |=> ref_sel == $past(pwdata[sas_pkg::CTRL_REF_LO +: 2]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select not updated");
  property p_diff;
    @(posedge pclk) disable iff (!presetn)
    sample_en |-> mux_diff == diff[mux_sel];
  endproperty
  a_diff: assert property (p_diff) else $error("channel mode mismatch");
  property p_acq;
    @(posedge pclk) disable iff (!presetn || low_power)
    $fell(sample_en) |-> a_len == $past(acq_eff);
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition length wrong");
  property p_no_idle;
    @(posedge pclk) disable iff (!presetn || low_power)
    res_wr && nxt[CH_W] |=> sample_en && mux_sel == $past(nxt[CH_W-1:0]);
  endproperty
  a_no_idle: assert property (p_no_idle) else $error("gap between channels");
  property p_done;
    @(posedge pclk) disable iff (!presetn)
    $rose(int_st[sas_pkg::INT_DONE]) |-> $past(res_wr) && !$past(nxt[CH_W]);
  endproperty
  a_done: assert property (p_done) else $error("scan done raised early");
  property p_range;
    @(posedge pclk) disable iff (!presetn)
    res_wr && (below || above) |=> int_st[sas_pkg::INT_RANGE];
  endproperty
  a_range: assert property (p_range) else $error("range event missed");
  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
    low_power |=> !sample_en && !conv_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("converter active in low power");
  property p_flags;
    @(posedge pclk) disable iff (!presetn)
    res_wr && below |=> below_q[$past(ch)];
  endproperty
  a_flags: assert property (p_flags) else $error("below flag not set");
endmodule

// >>> tb/sas_adc_model.sv
`timescale 1ns/10ps
module sas_adc_model (
  // Clock
  input  wire logic        pclk,
  // Mux and converter controls
  input  wire logic [3:0]  mux_sel,
  input  wire logic        mux_diff,
  input  wire logic        conv_en,
  // Result to the sequencer
  output logic      [11:0] adc_data
);
  // Code per selected pin and single-ended/differential mode; inverse when conv_en is low
  always @(posedge pclk)
  begin
    if (conv_en)
      adc_data <= {mux_sel, (mux_diff ? 8'h80 : 8'h11)};
    else
      adc_data <= ~{mux_sel, (mux_diff ? 8'h80 : 8'h11)};
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  mux_sel;
  logic        mux_diff;
  logic        temp_sel;
  logic        temp_bias_en;
  logic [1:0]  ref_sel;
  logic        ref_ext_pin;
  logic        sample_en;
  logic        conv_en;
  logic [11:0] adc_data;
  logic        low_power;
  logic        irq;
  int          n_errors;
  int          total_checks;
  int          cyc;

  sas_seq #(.NCH(16)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mux_sel(mux_sel), .mux_diff(mux_diff), .temp_sel(temp_sel),
    .temp_bias_en(temp_bias_en), .ref_sel(ref_sel), .ref_ext_pin(ref_ext_pin),
    .sample_en(sample_en), .conv_en(conv_en), .adc_data(adc_data),
    .low_power(low_power), .irq(irq)
  );

  sas_adc_model u_adc (
    .pclk(pclk), .mux_sel(mux_sel), .mux_diff(mux_diff), .conv_en(conv_en),
    .adc_data(adc_data)
  );

  always #12.5 pclk = ~pclk;

  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
  endtask

  // Bounded wait for conversion or any activity to reach a level
  task automatic wait_act(input logic lvl, input logic conv_only);
    int k;
    k = 0;
    while ((conv_only ? conv_en : (sample_en | conv_en)) !== lvl && k < 300)
    begin
      @(posedge pclk);
      k++;
    end
    chkb(k < 300, 1'b1);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(sas_pkg::A_ACQ, q);
    chk(q, 32'h4);
    rd(sas_pkg::A_LIM_HI, q);
    chk(q, 32'hFFF);
    rd(sas_pkg::A_LIM_LO, q);
    chk(q, 32'h0);
    apb(8'h30, 1'b0, 32'h0, q, e);
    chk(q, 32'h0);
    chkb(e, 1'b1);
  endtask

  task automatic t_scan;
    logic [31:0] q;
    int          n;
    logic        sd;
    logic        st;
    n = 0;
    sd = 1'b0;
    st = 1'b0;
    wr(sas_pkg::A_CHEN, 32'h8005);
    wr(sas_pkg::A_DIFF, 32'h4);
    wr(sas_pkg::A_ACQ, 32'h2);
    wr(sas_pkg::A_INT_EN, 32'h1);
    wr(sas_pkg::A_CTRL, 32'h22);
    wait_act(1'b1, 1'b0);
    while ((sample_en | conv_en) === 1'b1 && n < 300)
    begin
      if (mux_sel === 4'h2)
        sd |= mux_diff;
      if (mux_sel === 4'hF)
        st |= temp_sel;
      n++;
      @(posedge pclk);
    end
    chk(32'(n), 32'(3 * (2 + sas_pkg::CONV_CYC)));
    chkb(sd, 1'b1);
    chkb(st, 1'b1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chkb(irq, 1'b1);
    rd(sas_pkg::A_RESULT, q);
    chk(q, 32'h11);
    rd(8'h48, q);
    chk(q, 32'h280);
    rd(8'h7C, q);
    chk(q, 32'hF11);
    rd(sas_pkg::A_INT_ST, q);
    chk(q, 32'h1);
    wr(sas_pkg::A_INT_EN, 32'h0);
    @(negedge pclk);
    chkb(irq, 1'b0);
    wr(sas_pkg::A_INT_EN, 32'h1);
    @(negedge pclk);
    chkb(irq, 1'b1);
    wr(sas_pkg::A_INT_CLR, 32'h1);
    @(negedge pclk);
    chkb(irq, 1'b0);
  endtask

  task automatic t_range;
    logic [31:0] q;
    wr(sas_pkg::A_LIM_LO, 32'h100);
    wr(sas_pkg::A_LIM_HI, 32'hE00);
    wr(sas_pkg::A_INT_EN, 32'h2);
    wr(sas_pkg::A_CTRL, 32'h2);
    wait_act(1'b1, 1'b1);
    wait_act(1'b0, 1'b1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chkb(irq, 1'b1);
    chkb(sample_en | conv_en, 1'b1);
    wait_act(1'b0, 1'b0);
    repeat (2) @(posedge pclk);
    rd(sas_pkg::A_BELOW, q);
    chk(q, 32'h1);
    rd(sas_pkg::A_ABOVE, q);
    chk(q, 32'h8000);
    wr(sas_pkg::A_BELOW, 32'h1);
    rd(sas_pkg::A_BELOW, q);
    chk(q, 32'h0);
    rd(sas_pkg::A_INT_ST, q);
    chk(q, 32'h3);
    wr(sas_pkg::A_INT_CLR, 32'h3);
    @(negedge pclk);
    chkb(irq, 1'b0);
  endtask

  task automatic t_ref;
    for (int r = 0; r < 4; r++)
    begin
      wr(sas_pkg::A_CTRL, 32'(r << 2) | (r == 3 ? 32'h30 : 32'h20));
      @(negedge pclk);
      chk(32'(ref_sel), 32'(r));
      chkb(ref_ext_pin, r == 3);
      chkb(temp_bias_en, 1'b1);
    end
    wr(sas_pkg::A_CTRL, 32'h0);
    @(negedge pclk);
    chkb(temp_bias_en, 1'b0);
  endtask

  task automatic t_low;
    int n;
    n = 0;
    wr(sas_pkg::A_ACQ, 32'h8);
    wr(sas_pkg::A_CHEN, 32'h1);
    wr(sas_pkg::A_CTRL, 32'h1);
    wait_act(1'b1, 1'b0);
    while ((sample_en | conv_en) === 1'b1 && n < 2 * (8 + sas_pkg::CONV_CYC))
    begin
      n++;
      @(posedge pclk);
    end
    chk(32'(n), 32'(2 * (8 + sas_pkg::CONV_CYC)));
    low_power <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chkb(sample_en | conv_en, 1'b0);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chkb(sample_en | conv_en, 1'b0);
    wr(sas_pkg::A_CTRL, 32'h0);
    low_power <= 1'b0;
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    low_power = 1'b0;
    n_errors = 0;
    total_checks = 0;
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_scan();
    t_range();
    t_ref();
    t_low();
    report_and_stop();
  end
endmodule
